// >>> include/pad_mux_pkg.sv
package pad_mux_pkg;
    localparam int NUM_PADS = 53;
    localparam int ATTR_W = 5;
    localparam int HI_W = NUM_PADS - 32;

    // Function selector codes
    localparam logic [1:0] FSEL_NORMAL = 2'h0;
    localparam logic [1:0] FSEL_GPIO = 2'h1;
    localparam logic [1:0] FSEL_THIRD = 2'h2;
    localparam logic [1:0] FSEL_FOURTH = 2'h3;
    localparam logic [1:0] FSEL_RESET = FSEL_NORMAL;

    // Register map, byte addresses
    localparam logic [11:0] ALT_FUNCTION_CTRL_BASE = 12'h000;
    localparam logic [11:0] PAD_ATTR_CTRL_BASE = 12'h100;
    localparam logic [11:0] IRQ_MASK_LO_ADDR = 12'h200;
    localparam logic [11:0] IRQ_MASK_HI_ADDR = 12'h204;
    localparam logic [11:0] IRQ_POL_LO_ADDR = 12'h208;
    localparam logic [11:0] IRQ_POL_HI_ADDR = 12'h20C;
    localparam logic [11:0] PAD_LEVEL_LO_ADDR = 12'h210;
    localparam logic [11:0] PAD_LEVEL_HI_ADDR = 12'h214;
    localparam logic [11:0] IRQ_TERM_LO_ADDR = 12'h218;
    localparam logic [11:0] IRQ_TERM_HI_ADDR = 12'h21C;

    // Pad attribute field positions
    localparam int ATTR_IE_BIT = 0;
    localparam int ATTR_SCHMITT_BIT = 1;
    localparam int ATTR_PU_BIT = 2;
    localparam int ATTR_PD_BIT = 3;
    localparam int ATTR_DS_BIT = 4;
    localparam logic [ATTR_W-1:0] ATTR_RESET = 5'h01;

    // Interrupt control reset values: masked, high-level sense
    localparam logic [NUM_PADS-1:0] IRQ_MASK_RESET = 53'h0;
    localparam logic [NUM_PADS-1:0] IRQ_POL_RESET = 53'h0;

    // Which pads offer each function; pads 0-15 port A, 16-31 B, 32-47 C, 48-52 D
    localparam logic [NUM_PADS-1:0] HAS_NORMAL = 53'h1F_FFFF_3FFF_FFFF;
    localparam logic [NUM_PADS-1:0] HAS_THIRD = 53'h0_FFFF_000F_7FE7;
    localparam logic [NUM_PADS-1:0] HAS_FOURTH = 53'h0_FF00_0000_07E0;
    // Mixed pads carrying a converter input under code 11, and those also under code 00
    localparam logic [NUM_PADS-1:0] ANALOG_ON_FOURTH = 53'h0_FF00_0000_0000;
    localparam logic [NUM_PADS-1:0] ANALOG_ON_NORMAL = 53'h0_F000_0000_0000;

    typedef enum logic [2:0] {
        REG_NONE = 3'h0,
        REG_FSEL = 3'h1,
        REG_ATTR = 3'h2,
        REG_WORD = 3'h3
    } reg_kind_t;
endpackage

// >>> src/pad_mux_control_combined_pad_irq.sv
module pad_mux_control_combined_pad_irq
    import pad_mux_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NUM_PADS-1:0] pad_in,
    output logic [NUM_PADS-1:0] pad_out,
    output logic [NUM_PADS-1:0] pad_oe,
    input wire logic [NUM_PADS-1:0] norm_out,
    input wire logic [NUM_PADS-1:0] norm_oe,
    output logic [NUM_PADS-1:0] norm_in,
    input wire logic [NUM_PADS-1:0] gpio_out,
    input wire logic [NUM_PADS-1:0] gpio_oe,
    output logic [NUM_PADS-1:0] gpio_in,
    input wire logic [NUM_PADS-1:0] third_out,
    input wire logic [NUM_PADS-1:0] third_oe,
    output logic [NUM_PADS-1:0] third_in,
    input wire logic [NUM_PADS-1:0] fourth_out,
    input wire logic [NUM_PADS-1:0] fourth_oe,
    output logic [NUM_PADS-1:0] fourth_in,
    output logic [NUM_PADS-1:0] analog_in,
    output logic [NUM_PADS-1:0] input_buffer_en,
    output logic [NUM_PADS-1:0] schmitt_sel,
    output logic [NUM_PADS-1:0] pullup_en,
    output logic [NUM_PADS-1:0] pulldown_en,
    output logic [NUM_PADS-1:0] drive_strength_sel,
    output logic combined_pad_irq
);

    function automatic reg_kind_t addr_kind(input logic [11:0] a);
        if (a[1:0] != 2'h0) begin
            addr_kind = REG_NONE;
        end else if (a[11:8] == ALT_FUNCTION_CTRL_BASE[11:8] && a[7:2] < 6'(NUM_PADS)) begin
            addr_kind = REG_FSEL;
        end else if (a[11:8] == PAD_ATTR_CTRL_BASE[11:8] && a[7:2] < 6'(NUM_PADS)) begin
            addr_kind = REG_ATTR;
        end else if (a >= IRQ_MASK_LO_ADDR && a <= IRQ_TERM_HI_ADDR) begin
            addr_kind = REG_WORD;
        end else begin
            addr_kind = REG_NONE;
        end
    endfunction

    // Splits a 53-bit vector into the low or high bus word
    function automatic logic [31:0] word_of(input logic [NUM_PADS-1:0] v, input logic hi);
        word_of = hi ? {{(32 - HI_W){1'b0}}, v[NUM_PADS-1:32]} : v[31:0];
    endfunction

    function automatic logic [NUM_PADS-1:0] word_merge(input logic [NUM_PADS-1:0] v, input logic hi,
                                                       input logic [31:0] d);
        word_merge = hi ? {d[HI_W-1:0], v[31:0]} : {v[NUM_PADS-1:32], d};
    endfunction

    // True when pad p has a function behind code c; code 01 always reaches the port bit
    function automatic logic offers(input int p, input logic [1:0] c);
        case (c)
            FSEL_NORMAL: offers = HAS_NORMAL[p];
            FSEL_GPIO: offers = 1'b1;
            FSEL_THIRD: offers = HAS_THIRD[p];
            default: offers = HAS_FOURTH[p];
        endcase
    endfunction

    logic [1:0] fsel_reg [NUM_PADS];
    logic [ATTR_W-1:0] attr_reg [NUM_PADS];
    logic [NUM_PADS-1:0] irq_mask_reg;
    logic [NUM_PADS-1:0] irq_pol_reg;
    logic [NUM_PADS-1:0] sync1_reg;
    logic [NUM_PADS-1:0] sync2_reg;
    logic [NUM_PADS-1:0] irq_term_reg;
    logic [NUM_PADS-1:0] pad_out_next;
    logic [NUM_PADS-1:0] pad_oe_next;
    logic [NUM_PADS-1:0] core_in_next;
    logic [NUM_PADS-1:0] analog_next;

    reg_kind_t kind;
    logic [5:0] idx;
    logic access;
    logic do_write;
    logic [31:0] rdata_next;

    assign kind = addr_kind(paddr);
    assign idx = paddr[7:2];
    // Wait state: pready rises one cycle into the access phase, so every output stays registered
    assign access = psel && penable && !pready;
    assign do_write = psel && penable && pready && pwrite && !pslverr;

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= access;
            pslverr <= access && (kind == REG_NONE);
            if (access && !pwrite) begin
                prdata <= rdata_next;
            end
        end
    end

    always_comb begin
        rdata_next = 32'h0;
        case (kind)
            REG_FSEL: rdata_next = {30'h0, fsel_reg[idx]};
            REG_ATTR: rdata_next = {27'h0, attr_reg[idx]};
            REG_WORD: begin
                case (paddr[4:3])
                    2'h0: rdata_next = word_of(irq_mask_reg, paddr[2]);
                    2'h1: rdata_next = word_of(irq_pol_reg, paddr[2]);
                    2'h2: rdata_next = word_of(sync2_reg, paddr[2]);
                    default: rdata_next = word_of(irq_term_reg, paddr[2]);
                endcase
            end
            default: rdata_next = 32'h0;
        endcase
    end

    always_ff @(posedge core_clk) begin
        for (int i = 0; i < NUM_PADS; i++) begin
            if (!nrst) begin
                fsel_reg[i] <= FSEL_RESET;
            end else if (do_write && kind == REG_FSEL && idx == 6'(i)) begin
                fsel_reg[i] <= pwdata[1:0];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        for (int i = 0; i < NUM_PADS; i++) begin
            if (!nrst) begin
                attr_reg[i] <= ATTR_RESET;
            end else if (do_write && kind == REG_ATTR && idx == 6'(i)) begin
                attr_reg[i] <= pwdata[ATTR_W-1:0];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            irq_mask_reg <= IRQ_MASK_RESET;
            irq_pol_reg <= IRQ_POL_RESET;
        end else if (do_write && kind == REG_WORD) begin
            if (paddr[4:3] == IRQ_MASK_LO_ADDR[4:3]) begin
                irq_mask_reg <= word_merge(irq_mask_reg, paddr[2], pwdata);
            end
            if (paddr[4:3] == IRQ_POL_LO_ADDR[4:3]) begin
                irq_pol_reg <= word_merge(irq_pol_reg, paddr[2], pwdata);
            end
        end
    end

    always_comb begin
        pad_out_next = '0;
        pad_oe_next = '0;
        for (int i = 0; i < NUM_PADS; i++) begin
            case (fsel_reg[i])
                FSEL_NORMAL: begin
                    pad_out_next[i] = offers(i, FSEL_NORMAL) & norm_out[i];
                    pad_oe_next[i] = offers(i, FSEL_NORMAL) & norm_oe[i];
                end
                FSEL_GPIO: begin
                    pad_out_next[i] = gpio_out[i];
                    pad_oe_next[i] = gpio_oe[i];
                end
                FSEL_THIRD: begin
                    pad_out_next[i] = offers(i, FSEL_THIRD) & third_out[i];
                    pad_oe_next[i] = offers(i, FSEL_THIRD) & third_oe[i];
                end
                default: begin
                    pad_out_next[i] = offers(i, FSEL_FOURTH) & fourth_out[i];
                    pad_oe_next[i] = offers(i, FSEL_FOURTH) & fourth_oe[i];
                end
            endcase
        end
    end

    always_comb begin
        core_in_next = '0;
        analog_next = '0;
        for (int i = 0; i < NUM_PADS; i++) begin
            if (pad_oe_next[i]) begin
                core_in_next[i] = attr_reg[i][ATTR_IE_BIT] & pad_out_next[i];
            end else begin
                core_in_next[i] = pad_in[i];
            end
            analog_next[i] = (ANALOG_ON_FOURTH[i] && fsel_reg[i] == FSEL_FOURTH) ||
                             (ANALOG_ON_NORMAL[i] && fsel_reg[i] == FSEL_NORMAL);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            pad_out <= '0;
            pad_oe <= '0;
        end else begin
            pad_out <= pad_out_next;
            pad_oe <= pad_oe_next;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            analog_in <= '0;
        end else begin
            analog_in <= analog_next;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            norm_in <= '0;
            gpio_in <= '0;
            third_in <= '0;
            fourth_in <= '0;
        end else begin
            // Unselected functions see low so a peripheral never reacts to a pad it does not own
            for (int i = 0; i < NUM_PADS; i++) begin
                norm_in[i] <= offers(i, FSEL_NORMAL) && fsel_reg[i] == FSEL_NORMAL && core_in_next[i];
                gpio_in[i] <= fsel_reg[i] == FSEL_GPIO && core_in_next[i];
                third_in[i] <= offers(i, FSEL_THIRD) && fsel_reg[i] == FSEL_THIRD && core_in_next[i];
                fourth_in[i] <= offers(i, FSEL_FOURTH) && fsel_reg[i] == FSEL_FOURTH && core_in_next[i];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        for (int i = 0; i < NUM_PADS; i++) begin
            if (!nrst) begin
                input_buffer_en[i] <= ATTR_RESET[ATTR_IE_BIT];
                schmitt_sel[i] <= ATTR_RESET[ATTR_SCHMITT_BIT];
                pullup_en[i] <= ATTR_RESET[ATTR_PU_BIT];
                pulldown_en[i] <= ATTR_RESET[ATTR_PD_BIT];
                drive_strength_sel[i] <= ATTR_RESET[ATTR_DS_BIT];
            end else begin
                input_buffer_en[i] <= attr_reg[i][ATTR_IE_BIT];
                schmitt_sel[i] <= attr_reg[i][ATTR_SCHMITT_BIT];
                pullup_en[i] <= attr_reg[i][ATTR_PU_BIT];
                pulldown_en[i] <= attr_reg[i][ATTR_PD_BIT];
                drive_strength_sel[i] <= attr_reg[i][ATTR_DS_BIT];
            end
        end
    end

    // taken from raw pad level, independent of selector
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            // Nothing but the second stage reads the first, which may still be settling
            sync1_reg <= pad_in;
            sync2_reg <= sync1_reg;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            irq_term_reg <= '0;
            combined_pad_irq <= 1'b0;
        end else begin
            irq_term_reg <= irq_mask_reg & (irq_pol_reg ^ sync2_reg);
            combined_pad_irq <= |irq_term_reg;
        end
    end

endmodule

// >>> verification/pad_mux_asserts.sv
module pad_mux_asserts
    import pad_mux_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [NUM_PADS-1:0] pad_in,
    input wire logic [NUM_PADS-1:0] norm_in,
    input wire logic [NUM_PADS-1:0] gpio_in,
    input wire logic [NUM_PADS-1:0] third_in,
    input wire logic [NUM_PADS-1:0] fourth_in,
    input wire logic [NUM_PADS-1:0] analog_in,
    input wire logic [NUM_PADS-1:0] input_buffer_en,
    input wire logic combined_pad_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    a_ready_pulse: assert property (pready |=> !pready) else $error("pready held too long");
    a_ready_cause: assert property (pready |-> $past(psel && penable)) else $error("pready without access");
    a_access_answer: assert property (psel && penable && !pready |=> pready) else $error("no answer after access");
    a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
    a_ie_reset_high: assert property ($rose(nrst) |-> input_buffer_en == {NUM_PADS{1'b1}})
        else $error("input buffer enable not set after reset");
    a_irq_masked_reset: assert property ($rose(nrst) |-> !combined_pad_irq [*4])
        else $error("interrupt raised while masked after reset");
    a_irq_steady: assert property ((!psel && $stable(pad_in)) [*6] |-> $stable(combined_pad_irq))
        else $error("interrupt changed with quiet inputs");
    a_one_owner: assert property (((norm_in & (gpio_in | third_in | fourth_in)) |
        (gpio_in & (third_in | fourth_in)) | (third_in & fourth_in)) == '0) else $error("two functions own a pad");
    a_offered_only: assert property (((third_in & ~HAS_THIRD) | (fourth_in & ~HAS_FOURTH)) == '0)
        else $error("unoffered function active");
    a_analog_pads: assert property ((analog_in & ~ANALOG_ON_FOURTH) == '0)
        else $error("analog path on a digital pad");
endmodule
bind pad_mux_control_combined_pad_irq pad_mux_asserts u_chk (.core_clk(core_clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .pad_in(pad_in), .norm_in(norm_in),
    .gpio_in(gpio_in), .third_in(third_in), .fourth_in(fourth_in), .analog_in(analog_in),
    .input_buffer_en(input_buffer_en), .combined_pad_irq(combined_pad_irq));

// >>> verification/pad_side_model.sv
module pad_side_model
    import pad_mux_pkg::*;
(
    input wire logic [NUM_PADS-1:0] pad_out,
    input wire logic [NUM_PADS-1:0] pad_oe,
    input wire logic [NUM_PADS-1:0] ext_level,
    output logic [NUM_PADS-1:0] pad_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // A driven pad reads back its own drive; an undriven pad shows the outside level
    assign pad_in = (pad_out & pad_oe) | (ext_level & ~pad_oe);
endmodule

// >>> verification/test_pad_mux_control_combined_pad_irq.sv
module test_pad_mux_control_combined_pad_irq
    import pad_mux_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rq;
    logic pready, pslverr, re, combined_pad_irq;
    logic [NUM_PADS-1:0] pad_in, pad_out, pad_oe, norm_in, gpio_in, third_in, fourth_in, analog_in;
    logic [NUM_PADS-1:0] input_buffer_en, schmitt_sel, pullup_en, pulldown_en, drive_strength_sel;
    logic [NUM_PADS-1:0] norm_out = '0, norm_oe = '0, gpio_out = '0, gpio_oe = '0, ext_level = '0;
    logic [NUM_PADS-1:0] third_out = '0, third_oe = '0, fourth_out = '0, fourth_oe = '0;
    int n_mismatch = 0, num_checks = 0;
    always #4 core_clk = ~core_clk;
    pad_mux_control_combined_pad_irq dut (.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .norm_out(norm_out), .norm_oe(norm_oe),
        .norm_in(norm_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_in(gpio_in), .third_out(third_out),
        .third_oe(third_oe), .third_in(third_in), .fourth_out(fourth_out), .fourth_oe(fourth_oe),
        .fourth_in(fourth_in), .analog_in(analog_in), .input_buffer_en(input_buffer_en),
        .schmitt_sel(schmitt_sel), .pullup_en(pullup_en), .pulldown_en(pulldown_en),
        .drive_strength_sel(drive_strength_sel), .combined_pad_irq(combined_pad_irq));
    pad_side_model pads (.pad_out(pad_out), .pad_oe(pad_oe), .ext_level(ext_level), .pad_in(pad_in));
    task tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Request held until pready is sampled high; data and error taken at that edge
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        // Ends once pready is seen high; only the watchdog ends it if pready never rises
        while (pready !== 1'b1) begin
            @(posedge core_clk);
        end
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk({re, rq}, {1'b0, exp});
    endtask
    task settle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    initial begin
        repeat (20) @(posedge core_clk);
        nrst <= 1'b1;
        rd(ALT_FUNCTION_CTRL_BASE + 12'h024, 32'h0);
        rd(PAD_ATTR_CTRL_BASE, {27'h0, ATTR_RESET});
        rd(IRQ_MASK_LO_ADDR, 32'h0);
        rd(IRQ_POL_HI_ADDR, 32'h0);
        apb(1'b0, 12'h300, 32'h0);
        chk({re, rq}, {1'b1, 32'h0});
        $display("test reset values done");
        ext_level[9] <= 1'b1;
        ext_level[3] <= 1'b1;
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, ALT_FUNCTION_CTRL_BASE + 12'h024, 32'(c));
            settle(3);
            chk({norm_in[9], gpio_in[9], third_in[9], fourth_in[9]}, 4'b1000 >> c);
        end
        fourth_out[9] <= 1'b1;
        fourth_oe[9] <= 1'b1;
        norm_out[30:29] <= 2'b11;
        norm_oe[30:29] <= 2'b11;
        settle(3);
        chk({pad_oe[9], pad_out[9], fourth_in[9]}, 3'b111);
        chk({pad_oe[30:29], pad_out[30:29], norm_in[30:29]}, 6'b010101);
        apb(1'b1, ALT_FUNCTION_CTRL_BASE + 12'h00C, 32'h2);
        third_out[3] <= 1'b1;
        third_oe[3] <= 1'b1;
        settle(3);
        chk({pad_oe[3], third_in[3]}, 2'b00);
        rd(ALT_FUNCTION_CTRL_BASE + 12'h010, 32'h0);
        apb(1'b1, ALT_FUNCTION_CTRL_BASE + 12'h00C, 32'h1);
        gpio_out[3] <= 1'b1;
        gpio_oe[3] <= 1'b1;
        settle(4);
        chk({pad_oe[3], pad_out[3], gpio_in[3]}, 3'b111);
        apb(1'b1, PAD_ATTR_CTRL_BASE + 12'h00C, 32'h0);
        settle(4);
        chk({input_buffer_en[3], pad_out[3], gpio_in[3]}, 3'b010);
        apb(1'b1, PAD_ATTR_CTRL_BASE + 12'h01C, 32'h1E);
        gpio_oe[3] <= 1'b0;
        settle(4);
        chk(gpio_in[3], 1'b1);
        chk({drive_strength_sel[7], pulldown_en[7], pullup_en[7], schmitt_sel[7], input_buffer_en[7]}, 5'h1E);
        rd(PAD_ATTR_CTRL_BASE + 12'h01C, 32'h1E);
        $display("test functions and attributes done");
        settle(6);
        chk(combined_pad_irq, 1'b0);
        apb(1'b1, IRQ_MASK_LO_ADDR, 32'h200);
        settle(6);
        chk(combined_pad_irq, 1'b1);
        rd(IRQ_TERM_LO_ADDR, 32'h200);
        apb(1'b1, IRQ_POL_LO_ADDR, 32'h200);
        settle(6);
        chk(combined_pad_irq, 1'b0);
        apb(1'b1, IRQ_MASK_LO_ADDR, 32'h0);
        apb(1'b1, IRQ_MASK_HI_ADDR, 32'h100);
        ext_level[40] <= 1'b1;
        settle(6);
        chk(combined_pad_irq, 1'b1);
        rd(PAD_LEVEL_HI_ADDR, 32'h100);
        ext_level[40] <= 1'b0;
        settle(2);
        chk(combined_pad_irq, 1'b1);
        settle(4);
        chk(combined_pad_irq, 1'b0);
        $display("test interrupts done");
        apb(1'b1, ALT_FUNCTION_CTRL_BASE + 12'h0A0, 32'h3);
        settle(3);
        chk({analog_in[40], analog_in[44]}, 2'b11);
        apb(1'b1, ALT_FUNCTION_CTRL_BASE + 12'h0A0, 32'h0);
        settle(3);
        chk({analog_in[40], analog_in[44]}, 2'b01);
        nrst <= 1'b0;
        settle(2);
        nrst <= 1'b1;
        rd(IRQ_MASK_HI_ADDR, 32'h0);
        $display("test analog and second reset done");
        tally_and_finish;
    end
    initial begin
        repeat (5000) @(posedge core_clk);
        n_mismatch++;
        tally_and_finish;
    end
endmodule
